/* File: hdl/btu_pkg.sv */
// Package for the bit test unit: opcode fields, sizes, modes and port bundles.
package btu_pkg;
  localparam logic [15:0] BTU_PREFIX_WORD = 16'h7a02;
  localparam logic [1:0] BTU_MODE_REG = 2'h2;
  localparam logic [1:0] BTU_MODE_IND = 2'h0;
  localparam logic [1:0] BTU_MODE_EAM = 2'h1;
  localparam logic [6:0] BTU_OP_STATIC = 7'h13;
  localparam logic [6:0] BTU_OP_DYN = 7'h13;
  localparam logic [1:0] BTU_MODE_DYN = 2'h0;
  localparam int BTU_W_MSB = 8;
  localparam int BTU_OPC_MSB = 15;
  localparam int BTU_OPC_LSB = 9;
  localparam int BTU_MODE_MSB = 15;
  localparam int BTU_MODE_LSB = 14;
  localparam int BTU_SUB_MSB = 13;
  localparam int BTU_SUB_LSB = 9;
  localparam logic [4:0] BTU_SUB_CODE = 5'h13;
  localparam int BTU_DST_MSB = 7;
  localparam int BTU_DST_LSB = 4;
  localparam int BTU_EXT_DST_MSB = 11;
  localparam int BTU_EXT_DST_LSB = 8;
  localparam int BTU_IMM_MSB = 3;
  localparam int BTU_IMM_LSB = 0;
  localparam logic [3:0] BTU_REG_ZERO = 4'h0;
  localparam logic [1:0] BTU_EXT_ONE = 2'h1;
  localparam logic [1:0] BTU_EXT_THREE = 2'h3;

  typedef enum logic [1:0] {
    BTU_SZ_BYTE = 2'h0,
    BTU_SZ_WORD = 2'h1,
    BTU_SZ_LONG = 2'h2
  } btu_size_t;

  typedef enum logic [1:0] {
    BTU_ADDR_COMPACT = 2'h0,
    BTU_ADDR_SEGMENTED = 2'h1,
    BTU_ADDR_LINEAR = 2'h2
  } btu_addr_mode_t;

  typedef enum logic [1:0] {
    BTU_DST_REG = 2'h0,
    BTU_DST_IND = 2'h1,
    BTU_DST_EAM = 2'h2
  } btu_dst_kind_t;

  typedef struct packed {
    logic valid;
    logic dynamic;
    btu_size_t size;
    btu_dst_kind_t dst_kind;
    logic [3:0] dst_reg;
    logic [4:0] bit_num;
    logic [3:0] src_reg;
    logic ptr_long;
    logic [1:0] ext_words;
    logic illegal;
  } btu_decode_t;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic pv;
    logic d;
    logic h;
  } btu_flags_t;
endpackage

/* File: hdl/btu_decode.sv */
// Combinational opcode decoder for the bit test group.
`timescale 1ns/1ns
module btu_decode (
  input wire logic [15:0] op_word,
  input wire logic [15:0] ext_word,
  input wire logic prefixed,
  input wire logic [1:0] ea_ext_words,
  input wire btu_pkg::btu_addr_mode_t addr_mode,
  output btu_pkg::btu_decode_t dec
);
  logic [1:0] mode;
  logic hit_static;
  logic hit_dyn;
  logic [3:0] dst_field;

  always_comb begin
    mode = op_word[btu_pkg::BTU_MODE_MSB:btu_pkg::BTU_MODE_LSB];
    dst_field = op_word[btu_pkg::BTU_DST_MSB:btu_pkg::BTU_DST_LSB];
    hit_static = op_word[btu_pkg::BTU_SUB_MSB:btu_pkg::BTU_SUB_LSB] == btu_pkg::BTU_SUB_CODE &&
      mode != btu_pkg::BTU_MODE_DYN |
      (mode == btu_pkg::BTU_MODE_IND && dst_field != btu_pkg::BTU_REG_ZERO);
    hit_dyn = op_word[btu_pkg::BTU_SUB_MSB:btu_pkg::BTU_SUB_LSB] == btu_pkg::BTU_SUB_CODE &&
      mode == btu_pkg::BTU_MODE_DYN && dst_field == btu_pkg::BTU_REG_ZERO;
    dec = '0;
    dec.valid = hit_static | hit_dyn;
    dec.dynamic = hit_dyn;
    if (prefixed) begin
      dec.size = btu_pkg::BTU_SZ_LONG;
    end else if (op_word[btu_pkg::BTU_W_MSB]) begin
      dec.size = btu_pkg::BTU_SZ_WORD;
    end else begin
      dec.size = btu_pkg::BTU_SZ_BYTE;
    end
    dec.ptr_long = addr_mode != btu_pkg::BTU_ADDR_COMPACT;
    if (hit_dyn) begin
      // The dynamic form takes its source register from the opcode and its destination from a second word.
      dec.dst_kind = btu_pkg::BTU_DST_REG;
      dec.src_reg = op_word[btu_pkg::BTU_IMM_MSB:btu_pkg::BTU_IMM_LSB];
      dec.dst_reg = ext_word[btu_pkg::BTU_EXT_DST_MSB:btu_pkg::BTU_EXT_DST_LSB];
    end else begin
      dec.dst_reg = dst_field;
      dec.bit_num = {op_word[btu_pkg::BTU_W_MSB] & prefixed,
        op_word[btu_pkg::BTU_IMM_MSB:btu_pkg::BTU_IMM_LSB]};
      case (mode)
        btu_pkg::BTU_MODE_REG: dec.dst_kind = btu_pkg::BTU_DST_REG;
        btu_pkg::BTU_MODE_IND: dec.dst_kind = btu_pkg::BTU_DST_IND;
        btu_pkg::BTU_MODE_EAM: begin
          dec.dst_kind = btu_pkg::BTU_DST_EAM;
          dec.ext_words = ea_ext_words;
          dec.illegal = ea_ext_words < btu_pkg::BTU_EXT_ONE;
        end
        default: dec.illegal = 1'b1;
      endcase
    end
  end
endmodule

/* File: hdl/btu_core.sv */
// Bit test execution unit: decode, operand select and zero flag update.
// Behaviour
// - Zero flag becomes the inverse of the tested bit and every other flag is kept.
// - The tested operand is never written back to register or memory.
// - Legal positions are 0-7 for bytes, 0-15 for words and 0-31 for longwords.
// - A dynamic bit number is masked to its low 3, 4 or 5 bits by operand size.
// - Static forms take the bit number from the opcode, dynamic forms from a word register.
// - The dynamic form only tests a register destination.
// - Static effective-address forms carry the mode, bit number and 1 to 3 extension words.
// - The indirect pointer is a word in compact mode and a longword otherwise.
`timescale 1ns/1ns
module btu_core (
  clock,
  sys_rst,
  op_valid,
  op_word,
  ext_word,
  prefixed,
  ea_ext_words,
  addr_mode,
  src_reg_value,
  dst_value,
  flags_in,
  flags_out,
  done,
  illegal,
  dst_kind,
  dst_reg,
  src_reg,
  ptr_long,
  ext_words,
  write_back
);
  input wire logic clock;
  input wire logic sys_rst;
  input wire logic op_valid;
  input wire logic [15:0] op_word;
  input wire logic [15:0] ext_word;
  input wire logic prefixed;
  input wire logic [1:0] ea_ext_words;
  input wire btu_pkg::btu_addr_mode_t addr_mode;
  input wire logic [15:0] src_reg_value;
  input wire logic [31:0] dst_value;
  input wire btu_pkg::btu_flags_t flags_in;
  output btu_pkg::btu_flags_t flags_out;
  output logic done;
  output logic illegal;
  output btu_pkg::btu_dst_kind_t dst_kind;
  output logic [3:0] dst_reg;
  output logic [3:0] src_reg;
  output logic ptr_long;
  output logic [1:0] ext_words;
  output logic write_back;

  btu_pkg::btu_decode_t dec;
  logic [4:0] bit_sel;
  logic tested_bit;
  btu_pkg::btu_flags_t flags_d;

  btu_decode btu_decode_i (
    .op_word(op_word),
    .ext_word(ext_word),
    .prefixed(prefixed),
    .ea_ext_words(ea_ext_words),
    .addr_mode(addr_mode),
    .dec(dec)
  );

  function automatic logic [4:0] btu_mask(input btu_pkg::btu_size_t sz, input logic [4:0] n);
    case (sz)
      btu_pkg::BTU_SZ_BYTE: btu_mask = {2'h0, n[2:0]};
      btu_pkg::BTU_SZ_WORD: btu_mask = {1'h0, n[3:0]};
      default: btu_mask = n;
    endcase
  endfunction

  always_comb begin
    // Masking keeps every position inside the operand width.
    bit_sel = btu_mask(dec.size, dec.dynamic ? src_reg_value[4:0] : dec.bit_num);
    tested_bit = dst_value[bit_sel];
    flags_d = flags_in;
    flags_d.z = ~tested_bit;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags_out <= '0;
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      done <= op_valid & dec.valid & ~dec.illegal;
      illegal <= op_valid & (~dec.valid | dec.illegal);
      if (op_valid & dec.valid & ~dec.illegal) begin
        flags_out <= flags_d;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dst_kind <= btu_pkg::BTU_DST_REG;
      dst_reg <= '0;
      src_reg <= '0;
      ptr_long <= 1'b0;
      ext_words <= '0;
      write_back <= 1'b0;
    end else begin
      dst_kind <= dec.dst_kind;
      dst_reg <= dec.dst_reg;
      src_reg <= dec.src_reg;
      ptr_long <= dec.ptr_long;
      ext_words <= dec.ext_words;
      write_back <= 1'b0;
    end
  end

  property p_zflag;
    @(posedge clock) disable iff (sys_rst)
      op_valid & dec.valid & ~dec.illegal |=> flags_out.z == ~$past(tested_bit);
  endproperty
  a_zflag: assert property (p_zflag) else $error("zero flag wrong");
  property p_keep;
    @(posedge clock) disable iff (sys_rst)
      op_valid & dec.valid & ~dec.illegal |=> flags_out.c == $past(flags_in.c) &&
        flags_out.s == $past(flags_in.s) && flags_out.h == $past(flags_in.h) &&
        flags_out.pv == $past(flags_in.pv) && flags_out.d == $past(flags_in.d);
  endproperty
  a_keep: assert property (p_keep) else $error("other flag changed");
  property p_nowb;
    @(posedge clock) disable iff (sys_rst) ##1 !write_back;
  endproperty
  a_nowb: assert property (p_nowb) else $error("write back seen");
  property p_range;
    @(posedge clock) disable iff (sys_rst)
      dec.size == btu_pkg::BTU_SZ_BYTE |-> bit_sel < 5'h8;
  endproperty
  a_range: assert property (p_range) else $error("byte position out of range");
  property p_dynmask;
    @(posedge clock) disable iff (sys_rst)
      dec.dynamic && dec.size == btu_pkg::BTU_SZ_WORD |-> bit_sel == {1'b0, src_reg_value[3:0]};
  endproperty
  a_dynmask: assert property (p_dynmask) else $error("dynamic mask wrong");
  property p_dynreg;
    @(posedge clock) disable iff (sys_rst)
      op_valid & dec.dynamic |=> dst_kind == btu_pkg::BTU_DST_REG;
  endproperty
  a_dynreg: assert property (p_dynreg) else $error("dynamic not register");
  property p_ptr;
    @(posedge clock) disable iff (sys_rst)
      addr_mode == btu_pkg::BTU_ADDR_COMPACT |=> !ptr_long;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer width wrong");
  property p_long;
    @(posedge clock) disable iff (sys_rst) prefixed |-> dec.size == btu_pkg::BTU_SZ_LONG;
  endproperty
  a_long: assert property (p_long) else $error("prefix not long");
  property p_wrange;
    @(posedge clock) disable iff (sys_rst)
      dec.size == btu_pkg::BTU_SZ_WORD |-> bit_sel < 5'h10;
  endproperty
  a_wrange: assert property (p_wrange) else $error("word position out of range");
  property p_bytemask;
    @(posedge clock) disable iff (sys_rst)
      dec.dynamic && dec.size == btu_pkg::BTU_SZ_BYTE |->
        bit_sel == {2'h0, src_reg_value[2:0]};
  endproperty
  a_bytemask: assert property (p_bytemask) else $error("byte mask wrong");
  property p_longmask;
    @(posedge clock) disable iff (sys_rst)
      dec.dynamic && dec.size == btu_pkg::BTU_SZ_LONG |-> bit_sel == src_reg_value[4:0];
  endproperty
  a_longmask: assert property (p_longmask) else $error("long mask wrong");
  property p_static;
    @(posedge clock) disable iff (sys_rst)
      !dec.dynamic && dec.size != btu_pkg::BTU_SZ_BYTE |->
        bit_sel[3:0] == op_word[btu_pkg::BTU_IMM_MSB:btu_pkg::BTU_IMM_LSB];
  endproperty
  a_static: assert property (p_static) else $error("static number wrong");
  property p_dynsrc;
    @(posedge clock) disable iff (sys_rst)
      dec.dynamic |-> dec.src_reg == op_word[btu_pkg::BTU_IMM_MSB:btu_pkg::BTU_IMM_LSB];
  endproperty
  a_dynsrc: assert property (p_dynsrc) else $error("dynamic source wrong");
  property p_dyndst;
    @(posedge clock) disable iff (sys_rst)
      dec.dynamic |->
        dec.dst_reg == ext_word[btu_pkg::BTU_EXT_DST_MSB:btu_pkg::BTU_EXT_DST_LSB];
  endproperty
  a_dyndst: assert property (p_dyndst) else $error("dynamic destination wrong");
  property p_ptrlong;
    @(posedge clock) disable iff (sys_rst)
      addr_mode != btu_pkg::BTU_ADDR_COMPACT |=> ptr_long;
  endproperty
  a_ptrlong: assert property (p_ptrlong) else $error("pointer not long");
  property p_refuse;
    @(posedge clock) disable iff (sys_rst)
      op_valid & (~dec.valid | dec.illegal) |=> illegal && !done && $stable(flags_out);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused op touched flags");
  property p_hold;
    @(posedge clock) disable iff (sys_rst)
      !op_valid |=> $stable(flags_out) && !done && !illegal;
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved while idle");
  property p_done;
    @(posedge clock) disable iff (sys_rst)
      op_valid & dec.valid & ~dec.illegal |=> done && !illegal;
  endproperty
  a_done: assert property (p_done) else $error("legal op not done");
  property p_eamext;
    @(posedge clock) disable iff (sys_rst)
      dec.dst_kind == btu_pkg::BTU_DST_EAM && !dec.illegal |-> dec.ext_words != 2'h0;
  endproperty
  a_eamext: assert property (p_eamext) else $error("address form without words");
  property p_word;
    @(posedge clock) disable iff (sys_rst)
      !prefixed && op_word[btu_pkg::BTU_W_MSB] |-> dec.size == btu_pkg::BTU_SZ_WORD;
  endproperty
  a_word: assert property (p_word) else $error("size bit not word");
  property p_byte;
    @(posedge clock) disable iff (sys_rst)
      !prefixed && !op_word[btu_pkg::BTU_W_MSB] |-> dec.size == btu_pkg::BTU_SZ_BYTE;
  endproperty
  a_byte: assert property (p_byte) else $error("size bit not byte");
  c_dyn: cover property (@(posedge clock) op_valid & dec.dynamic);
  c_eam: cover property (@(posedge clock) op_valid & dec.dst_kind == btu_pkg::BTU_DST_EAM);
  c_zset: cover property (@(posedge clock) done & flags_out.z);
  c_long: cover property (@(posedge clock) op_valid & (dec.size == btu_pkg::BTU_SZ_LONG));
  c_refuse: cover property (@(posedge clock) illegal);
endmodule

/* File: tb/bit_test_unit_tb.sv */
// Self-checking bench for the bit test unit.
`timescale 1ns/1ns
module bit_test_unit_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  logic [15:0] op_word = 16'h0000;
  logic [15:0] ext_word = 16'h0000;
  logic prefixed = 1'b0;
  logic [1:0] ea_ext_words = 2'h1;
  btu_pkg::btu_addr_mode_t addr_mode = btu_pkg::BTU_ADDR_COMPACT;
  logic [15:0] src_reg_value = 16'h0000;
  logic [31:0] dst_value = 32'h00000000;
  btu_pkg::btu_flags_t flags_in = 6'h2d;
  btu_pkg::btu_flags_t flags_out;
  btu_pkg::btu_dst_kind_t dst_kind;
  logic done, illegal, ptr_long, write_back;
  logic [3:0] dst_reg, src_reg;
  logic [1:0] ext_words;
  logic [5:0] held;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  btu_core btu_core_i (.clock(clock), .sys_rst(sys_rst), .op_valid(op_valid),
    .op_word(op_word), .ext_word(ext_word), .prefixed(prefixed),
    .ea_ext_words(ea_ext_words), .addr_mode(addr_mode), .src_reg_value(src_reg_value),
    .dst_value(dst_value), .flags_in(flags_in), .flags_out(flags_out), .done(done),
    .illegal(illegal), .dst_kind(dst_kind), .dst_reg(dst_reg), .src_reg(src_reg),
    .ptr_long(ptr_long), .ext_words(ext_words), .write_back(write_back));

  always #5 clock = ~clock;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Valid stays high between calls so back-to-back operations are exercised.
  task automatic issue(input logic [15:0] op, input logic pre);
    op_valid = 1'b1;
    op_word = op;
    ext_word = 16'h0d00;
    prefixed = pre;
    @(posedge clock);
    @(negedge clock);
  endtask

  // Flags are inverted on every call so a stale copy of flags_in shows up.
  task automatic bt(input logic [15:0] op, input logic pre, input logic [15:0] src,
                    input logic [31:0] dst, input logic z);
    logic [5:0] f;
    f = ~flags_in;
    flags_in = f;
    src_reg_value = src;
    dst_value = dst;
    issue(op, pre);
    chk(done, 1'b1);
    chk(flags_out, {f[5], z, f[3:0]});
    chk(write_back, 1'b0);
  endtask

  task automatic t_static;
    bt(16'ha637, 1'b0, 16'h0000, 32'h00000080, 1'b0);
    bt(16'ha637, 1'b0, 16'h0000, 32'hffffff7f, 1'b1);
    bt(16'ha650, 1'b0, 16'h0000, 32'h00000100, 1'b1);
    bt(16'ha74f, 1'b0, 16'h0000, 32'h00008000, 1'b0);
    bt(16'ha74f, 1'b0, 16'h0000, 32'hffff7fff, 1'b1);
    bt(16'ha7cf, 1'b1, 16'h0000, 32'h80000000, 1'b0);
    bt(16'ha6cf, 1'b1, 16'h0000, 32'h00008000, 1'b0);
    bt(16'ha7e0, 1'b1, 16'h0000, 32'hfffeffff, 1'b1);
    chk(dst_kind, btu_pkg::BTU_DST_REG);
    chk(dst_reg, 4'he);
    $display("static register test ended");
  endtask

  task automatic t_dynamic;
    bt(16'h2605, 1'b0, 16'hfffb, 32'h00000008, 1'b0);
    bt(16'h2605, 1'b0, 16'hfffb, 32'hfffffff7, 1'b1);
    bt(16'h2705, 1'b0, 16'h003b, 32'h00000800, 1'b0);
    bt(16'h2705, 1'b1, 16'hffff, 32'h80000000, 1'b0);
    bt(16'h2705, 1'b1, 16'h0030, 32'h00010000, 1'b0);
    chk(dst_kind, btu_pkg::BTU_DST_REG);
    chk(src_reg, 4'h5);
    chk(dst_reg, 4'hd);
    $display("dynamic test ended");
  endtask

  task automatic t_indirect;
    for (int m = 0; m < 3; m++) begin
      addr_mode = btu_pkg::btu_addr_mode_t'(m);
      bt(16'h2637, 1'b0, 16'h0000, 32'h00000080, 1'b0);
      chk(dst_kind, btu_pkg::BTU_DST_IND);
      chk(ptr_long, m != 0);
    end
    $display("indirect test ended");
  endtask

  task automatic t_eam;
    for (int e = 1; e < 4; e++) begin
      ea_ext_words = e[1:0];
      bt(16'h6652, 1'b0, 16'h0000, 32'h00000004, 1'b0);
      chk(dst_kind, btu_pkg::BTU_DST_EAM);
      chk(ext_words, e);
    end
    held = flags_out;
    ea_ext_words = 2'h0;
    issue(16'h6652, 1'b0);
    chk({illegal, done}, 2'h2);
    issue(16'h0000, 1'b0);
    chk({illegal, done}, 2'h2);
    chk(flags_out, held);
    op_valid = 1'b0;
    @(negedge clock);
    chk({illegal, done, write_back}, 3'h0);
    $display("address mode and refusal test ended");
  endtask

  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    chk({done, illegal, write_back}, 3'h0);
    t_static();
    t_dynamic();
    t_indirect();
    t_eam();
    finish_test();
  end
endmodule
